// ---- hdl/oiu_irq_unit.sv ----
/*
 * Interrupt unit of a USB on-the-go transceiver: live event status, an
 * edge-selected interrupt latch, rising and falling masks, and the serial
 * two-wire slave that reaches them. Shared interrupt/output-enable pin.
 * Assumes comparator and pin levels arrive asynchronously; control bits
 * (auto-attach, session-over select, pin enable, low power) come from
 * control registers on the same clock.
 */
`timescale 1ns/1ps

// Overview of operation
// - Status at 08h shows live levels, read-only
// - Bits 2..5: D+, ID grounded, D-, ID floating
// - Bit 0 is the VBUS valid comparator
// - Bit 1 is the session valid comparator
// - Auto-attach on: bit 6 shows attach done
// - Else session-over select: bit 6 shows session end
// - Bit 7 is the car kit pulse detector
// - Latch readable at 0Ah and 0Bh
// - Falling mask at 0Ch/0Dh enables true-to-false
// - Rising mask at 0Eh/0Fh enables false-to-true
// - Set address forces written ones high
// - Clear address forces written ones low; a latch edge in that cycle wins
// - Pin drives low on interrupt when enabled, low power
module oiu_irq_unit (
   // Clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_n,
   // Analog event sources, asynchronous
   input  wire logic       i_vbus_valid,
   input  wire logic       i_sess_valid,
   input  wire logic       i_dplus_high_flag,
   input  wire logic       i_ident_grounded_flag,
   input  wire logic       i_dminus_high_flag,
   input  wire logic       i_ident_floating_flag,
   input  wire logic       i_dplus_pullup_connect,
   input  wire logic       i_sess_end,
   input  wire logic       i_carkit_pulse_flag,
   // Control bits from the control registers, same clock
   input  wire logic       i_autoattach_en,
   input  wire logic       i_sess_over_sel,
   input  wire logic       i_int_pin_en,
   input  wire logic       i_low_power,
   // Serial register interface pins
   input  wire logic       i_scl,
   input  wire logic       i_sda,
   output logic            o_sda_o,
   output logic            o_sda_oe,
   // Shared output-enable / interrupt pin
   output logic            o_oe_int_n_o,
   output logic            o_oe_int_oe,
   // Interrupt pending level
   output logic            o_int_pending
);

   oiu_pkg::oiu_state_t state_ff;
   oiu_pkg::oiu_state_t nxt_state;
   oiu_evt_if           evt ();

   logic [10:0] raw_in;
   logic [7:0]  live;
   logic        scl_s;
   logic        sda_s;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_cond;
   logic        stop_cond;
   logic        pending;
   logic [7:0]  rd_byte;

   // Bundle asynchronous inputs for the two-stage synchroniser
   assign raw_in = {i_sda, i_scl, i_carkit_pulse_flag, i_sess_end,
                    i_dplus_pullup_connect, i_ident_floating_flag,
                    i_dminus_high_flag, i_ident_grounded_flag,
                    i_dplus_high_flag, i_sess_valid, i_vbus_valid};

   // Live source vector, built from second-stage values only
   always_comb
   begin
      live = 8'h00;
      live[oiu_pkg::BIT_VBUS_VALID] = state_ff.sync2[0];
      live[oiu_pkg::BIT_SESS_VALID] = state_ff.sync2[1];
      live[oiu_pkg::BIT_DPLUS]      = state_ff.sync2[2];
      live[oiu_pkg::BIT_ID_GND]     = state_ff.sync2[3];
      live[oiu_pkg::BIT_DMINUS]     = state_ff.sync2[4];
      live[oiu_pkg::BIT_IDENT_FLOATING_FLAG]   = state_ff.sync2[5];
      // Auto-attach takes priority; with neither selected bit 6 reads zero
      if (i_autoattach_en)
         live[oiu_pkg::BIT_ATTACH] = state_ff.sync2[6];
      else if (i_sess_over_sel)
         live[oiu_pkg::BIT_ATTACH] = state_ff.sync2[7];
      live[oiu_pkg::BIT_CARKIT]     = state_ff.sync2[8];
   end

   // Serial line conditions from synchronised levels
   assign scl_s      = state_ff.sync2[9];
   assign sda_s      = state_ff.sync2[10];
   assign scl_rise   = scl_s & ~state_ff.scl_p;
   assign scl_fall   = ~scl_s & state_ff.scl_p;
   assign start_cond = scl_s & state_ff.scl_p & state_ff.sda_p & ~sda_s;
   assign stop_cond  = scl_s & state_ff.scl_p & ~state_ff.sda_p & sda_s;

   // Register read map; unmapped offsets read as zero
   function automatic logic [7:0] rd_sel(input logic [7:0] addr,
                                         input logic [7:0] lv,
                                         input oiu_pkg::oiu_state_t s);
      logic [7:0] d;
      d = 8'h00;
      case (addr)
         oiu_pkg::OFS_LIVE:      d = lv;
         oiu_pkg::OFS_LATCH_SET: d = s.latch;
         oiu_pkg::OFS_LATCH_CLR: d = s.latch;
         oiu_pkg::OFS_FALL_SET:  d = s.fall_en;
         oiu_pkg::OFS_FALL_CLR:  d = s.fall_en;
         oiu_pkg::OFS_RISE_SET:  d = s.rise_en;
         oiu_pkg::OFS_RISE_CLR:  d = s.rise_en;
         default:                d = 8'h00;
      endcase
      return d;
   endfunction

   // Byte the pointer selects, snapshotted when a read byte starts
   assign rd_byte = rd_sel(state_ff.ptr, live, state_ff);

   // Drive the edge/latch slice from registered state
   assign evt.live     = live;
   assign evt.prev     = state_ff.prev_live;
   assign evt.rise_en  = state_ff.rise_en;
   assign evt.fall_en  = state_ff.fall_en;
   assign evt.latch    = state_ff.latch;
   assign evt.armed    = state_ff.armed;
   assign evt.set_bits = (state_ff.wr_go && state_ff.wr_addr == oiu_pkg::OFS_LATCH_SET)
                         ? state_ff.wr_data : 8'h00;
   assign evt.clr_bits = (state_ff.wr_go && state_ff.wr_addr == oiu_pkg::OFS_LATCH_CLR)
                         ? state_ff.wr_data : 8'h00;

   oiu_edge_latch u_edge_latch (
      .evt (evt)
   );

   // Next-state logic: synchroniser, masks, latch and serial slave
   always_comb
   begin
      nxt_state           = state_ff;
      nxt_state.sync1     = raw_in;
      nxt_state.sync2     = state_ff.sync1;
      nxt_state.scl_p     = scl_s;
      nxt_state.sda_p     = sda_s;
      nxt_state.prev_live = live;
      // First cycle after reset only captures levels, avoiding false edges
      nxt_state.armed     = 1'b1;
      nxt_state.latch     = evt.nxt_latch;
      nxt_state.wr_go     = 1'b0;

      // Mask writes, applied one cycle after the data byte completes
      if (state_ff.wr_go)
      begin
         case (state_ff.wr_addr)
            oiu_pkg::OFS_FALL_SET: nxt_state.fall_en = state_ff.fall_en | state_ff.wr_data;
            oiu_pkg::OFS_FALL_CLR: nxt_state.fall_en = state_ff.fall_en & ~state_ff.wr_data;
            oiu_pkg::OFS_RISE_SET: nxt_state.rise_en = state_ff.rise_en | state_ff.wr_data;
            oiu_pkg::OFS_RISE_CLR: nxt_state.rise_en = state_ff.rise_en & ~state_ff.wr_data;
            default:               nxt_state.wr_go = 1'b0;
         endcase
      end

      // Serial slave: sample on SCL rise, change SDA on SCL fall
      if (start_cond)
      begin
         nxt_state.st     = oiu_pkg::SER_ADDR;
         nxt_state.bitcnt = 4'h0;
         nxt_state.sda_oe = 1'b0;
      end
      else if (stop_cond)
      begin
         nxt_state.st     = oiu_pkg::SER_IDLE;
         nxt_state.sda_oe = 1'b0;
      end
      else if (scl_rise)
      begin
         case (state_ff.st)
            oiu_pkg::SER_ADDR, oiu_pkg::SER_PTR, oiu_pkg::SER_WDATA:
            begin
               nxt_state.shreg  = {state_ff.shreg[6:0], sda_s};
               nxt_state.bitcnt = state_ff.bitcnt + 4'h1;
            end
            oiu_pkg::SER_RDATA:     nxt_state.bitcnt = state_ff.bitcnt + 4'h1;
            oiu_pkg::SER_RDATA_ACK: nxt_state.mack = ~sda_s;
            default:                nxt_state.mack = state_ff.mack;
         endcase
      end
      else if (scl_fall)
      begin
         case (state_ff.st)
            oiu_pkg::SER_ADDR:
            begin
               if (state_ff.bitcnt == oiu_pkg::BYTE_BITS)
               begin
                  // Answer only our own address; others are left alone
                  if (state_ff.shreg[7:1] == oiu_pkg::DEV_ADDR)
                  begin
                     nxt_state.st     = oiu_pkg::SER_ADDR_ACK;
                     nxt_state.rw     = state_ff.shreg[0];
                     nxt_state.sda_oe = 1'b1;
                  end
                  else
                     nxt_state.st = oiu_pkg::SER_IDLE;
               end
            end
            oiu_pkg::SER_ADDR_ACK, oiu_pkg::SER_RDATA_ACK:
            begin
               nxt_state.bitcnt = 4'h0;
               if ((state_ff.st == oiu_pkg::SER_ADDR_ACK && state_ff.rw) ||
                   (state_ff.st == oiu_pkg::SER_RDATA_ACK && state_ff.mack))
               begin
                  // Snapshot the byte now; the pointer then advances
                  nxt_state.shreg  = rd_byte;
                  nxt_state.sda_oe = ~rd_byte[7];
                  nxt_state.ptr    = state_ff.ptr + 8'h01;
                  nxt_state.st     = oiu_pkg::SER_RDATA;
               end
               else if (state_ff.st == oiu_pkg::SER_ADDR_ACK)
               begin
                  nxt_state.sda_oe = 1'b0;
                  nxt_state.st     = oiu_pkg::SER_PTR;
               end
               else
               begin
                  nxt_state.sda_oe = 1'b0;
                  nxt_state.st     = oiu_pkg::SER_IDLE;
               end
            end
            oiu_pkg::SER_PTR, oiu_pkg::SER_WDATA:
            begin
               if (state_ff.bitcnt == oiu_pkg::BYTE_BITS)
               begin
                  nxt_state.sda_oe = 1'b1;
                  if (state_ff.st == oiu_pkg::SER_PTR)
                  begin
                     nxt_state.ptr = state_ff.shreg;
                     nxt_state.st  = oiu_pkg::SER_PTR_ACK;
                  end
                  else
                  begin
                     nxt_state.wr_go   = 1'b1;
                     nxt_state.wr_addr = state_ff.ptr;
                     nxt_state.wr_data = state_ff.shreg;
                     nxt_state.ptr     = state_ff.ptr + 8'h01;
                     nxt_state.st      = oiu_pkg::SER_WDATA_ACK;
                  end
               end
            end
            oiu_pkg::SER_PTR_ACK, oiu_pkg::SER_WDATA_ACK:
            begin
               nxt_state.sda_oe = 1'b0;
               nxt_state.bitcnt = 4'h0;
               nxt_state.st     = oiu_pkg::SER_WDATA;
            end
            oiu_pkg::SER_RDATA:
            begin
               if (state_ff.bitcnt == oiu_pkg::BYTE_BITS)
               begin
                  // Release the line for the master's acknowledge
                  nxt_state.sda_oe = 1'b0;
                  nxt_state.st     = oiu_pkg::SER_RDATA_ACK;
               end
               else
               begin
                  nxt_state.shreg  = {state_ff.shreg[6:0], 1'b0};
                  nxt_state.sda_oe = ~state_ff.shreg[6];
               end
            end
            default: nxt_state.sda_oe = 1'b0;
         endcase
      end
   end

   // State register
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         state_ff         <= '0;
         state_ff.sync1   <= 11'h600;  // Serial lines idle high
         state_ff.sync2   <= 11'h600;
         state_ff.scl_p   <= 1'b1;
         state_ff.sda_p   <= 1'b1;
         state_ff.latch   <= oiu_pkg::RST_LATCH;
         state_ff.fall_en <= oiu_pkg::RST_MASK;
         state_ff.rise_en <= oiu_pkg::RST_MASK;
         state_ff.ptr     <= oiu_pkg::RST_PTR;
         state_ff.st      <= oiu_pkg::SER_IDLE;
      end
      else
         state_ff <= nxt_state;
   end

   // Interrupt indication and the shared pin
   assign pending       = |state_ff.latch;
   assign o_int_pending = pending;
   assign o_oe_int_oe   = i_int_pin_en & i_low_power;
   assign o_oe_int_n_o  = ~pending;
   assign o_sda_o       = 1'b0;                             // Open drain: only pulls low
   assign o_sda_oe      = state_ff.sda_oe;

endmodule // oiu_irq_unit

// ---- inc/oiu_pkg.sv ----
/*
 * Constants and types shared by the transceiver interrupt unit and its
 * host model and test bench.
 * Assumes a single 100 MHz core clock and a synchronous active-low reset.
 */
package oiu_pkg;

   // Register offsets on the serial register interface
   localparam logic [7:0] OFS_LIVE      = 8'h08;
   localparam logic [7:0] OFS_LATCH_SET = 8'h0A;
   localparam logic [7:0] OFS_LATCH_CLR = 8'h0B;
   localparam logic [7:0] OFS_FALL_SET  = 8'h0C;
   localparam logic [7:0] OFS_FALL_CLR  = 8'h0D;
   localparam logic [7:0] OFS_RISE_SET  = 8'h0E;
   localparam logic [7:0] OFS_RISE_CLR  = 8'h0F;

   // Bit positions of the eight event sources
   localparam int BIT_VBUS_VALID = 0;
   localparam int BIT_SESS_VALID = 1;
   localparam int BIT_DPLUS      = 2;
   localparam int BIT_ID_GND     = 3;
   localparam int BIT_DMINUS     = 4;
   localparam int BIT_IDENT_FLOATING_FLAG   = 5;
   localparam int BIT_ATTACH     = 6;
   localparam int BIT_CARKIT     = 7;

   // Values after reset
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [7:0] RST_MASK  = 8'h00;
   localparam logic [7:0] RST_PTR   = 8'h00;

   // Serial slave address, value arbitrary
   localparam logic [6:0] DEV_ADDR  = 7'h2D;

   // Bits in a serial byte
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // Serial slave states
   typedef enum logic [3:0] {
      SER_IDLE,
      SER_ADDR,
      SER_ADDR_ACK,
      SER_PTR,
      SER_PTR_ACK,
      SER_WDATA,
      SER_WDATA_ACK,
      SER_RDATA,
      SER_RDATA_ACK
   } oiu_ser_st_t;

   // All state of the top module
   typedef struct packed {
      logic [10:0] sync1;
      logic [10:0] sync2;
      logic        scl_p;
      logic        sda_p;
      logic [7:0]  prev_live;
      logic        armed;
      logic [7:0]  latch;
      logic [7:0]  fall_en;
      logic [7:0]  rise_en;
      oiu_ser_st_t st;
      logic [3:0]  bitcnt;
      logic [7:0]  shreg;
      logic [7:0]  ptr;
      logic        rw;
      logic        mack;
      logic        sda_oe;
      logic        wr_go;
      logic [7:0]  wr_addr;
      logic [7:0]  wr_data;
   } oiu_state_t;

endpackage

// ---- inc/oiu_evt_if.sv ----
/*
 * Carrier between the interrupt unit core and its per-source latch logic.
 * Assumes both ends sit on the same core clock.
 */
`timescale 1ns/1ps
interface oiu_evt_if;
   logic [7:0] live;
   logic [7:0] prev;
   logic [7:0] rise_en;
   logic [7:0] fall_en;
   logic [7:0] latch;
   logic [7:0] set_bits;
   logic [7:0] clr_bits;
   logic       armed;
   logic [7:0] nxt_latch;

   modport core (
      output live, prev, rise_en, fall_en, latch, set_bits, clr_bits, armed,
      input  nxt_latch
   );
   modport edge_side (
      input  live, prev, rise_en, fall_en, latch, set_bits, clr_bits, armed,
      output nxt_latch
   );
endinterface

// ---- hdl/oiu_edge_latch.sv ----
/*
 * Per-source transition detection and next value of the interrupt latch.
 * Purely combinational; the core registers the result.
 * Assumes live and prev are already synchronised to the core clock.
 */
`timescale 1ns/1ps
module oiu_edge_latch (
   // Event carrier
   oiu_evt_if.edge_side evt
);

   // One slice per source; an event or a host set beats a host clear
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_src
         logic rise_hit;
         logic fall_hit;
         assign rise_hit = evt.armed & evt.live[g] & ~evt.prev[g] & evt.rise_en[g];
         assign fall_hit = evt.armed & ~evt.live[g] & evt.prev[g] & evt.fall_en[g];
         assign evt.nxt_latch[g] = rise_hit | fall_hit | evt.set_bits[g]
                                   | (evt.latch[g] & ~evt.clr_bits[g]);
      end
   endgenerate

endmodule // oiu_edge_latch

// ---- tb/oiu_irq_unit_properties.sv ----
/* Checker for the interrupt unit top ports.
   Assumes binding to oiu_irq_unit on its single core clock. */
`timescale 1ns/1ps
module oiu_irq_unit_properties (
   // Clock and reset
   input wire logic i_core_clk, i_rst_n,
   // Event sources
   input wire logic i_vbus_valid, i_sess_valid, i_dplus_high_flag, i_ident_grounded_flag,
   input wire logic i_dminus_high_flag, i_ident_floating_flag, i_dplus_pullup_connect,
   input wire logic i_sess_end, i_carkit_pulse_flag,
   // Control bits
   input wire logic i_autoattach_en, i_sess_over_sel, i_int_pin_en, i_low_power,
   // Serial pins and interrupt pin
   input wire logic i_scl, i_sda, o_sda_o, o_sda_oe,
   input wire logic o_oe_int_n_o, o_oe_int_oe, o_int_pending
);
   logic [12:0] in_q;
   logic [3:0]  quiet_ff;
   logic [3:0]  hi_ff;
   wire  [12:0] ins = {i_vbus_valid, i_sess_valid, i_dplus_high_flag, i_ident_grounded_flag,
      i_dminus_high_flag, i_ident_floating_flag, i_dplus_pullup_connect, i_sess_end,
      i_carkit_pulse_flag, i_autoattach_en, i_sess_over_sel, i_int_pin_en, i_low_power};

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   // Quiet span: no input moved and SCL high, so nothing may touch the latch
   always_ff @(posedge i_core_clk)
   begin
      in_q     <= ins;
      quiet_ff <= (!i_rst_n || ins != in_q || !i_scl) ? 4'h0 :
                  quiet_ff + {3'h0, quiet_ff != 4'hF};
      hi_ff    <= (!i_rst_n || !i_scl) ? 4'h0 : hi_ff + {3'h0, hi_ff != 4'hF};
   end

   pin_level_a: assert property (o_oe_int_n_o == !o_int_pending)
      else $error("pin level differs from pending");
   pin_enable_a: assert property (o_oe_int_oe == (i_int_pin_en && i_low_power))
      else $error("pin enable wrong");
   pin_drive_a: assert property (o_oe_int_oe && o_int_pending |-> !o_oe_int_n_o)
      else $error("pin not low on interrupt");
   latch_hold_a: assert property (quiet_ff >= 4'h8 |-> $stable(o_int_pending))
      else $error("pending moved without cause");
   reset_clear_a: assert property ($rose(i_rst_n) |-> !o_int_pending [*2])
      else $error("pending after reset");
   ack_timing_a: assert property (!$stable(o_sda_oe) |-> !i_scl)
      else $error("SDA moved while SCL high");
   idle_release_a: assert property (hi_ff >= 4'hC |-> !o_sda_oe)
      else $error("SDA held on idle bus");
   open_drain_a: assert property (o_sda_o == 1'b0)
      else $error("SDA driven high");
endmodule // oiu_irq_unit_properties

bind oiu_irq_unit oiu_irq_unit_properties oiu_irq_unit_properties_inst (
   .i_core_clk, .i_rst_n, .i_vbus_valid, .i_sess_valid, .i_dplus_high_flag,
   .i_ident_grounded_flag, .i_dminus_high_flag, .i_ident_floating_flag,
   .i_dplus_pullup_connect, .i_sess_end, .i_carkit_pulse_flag, .i_autoattach_en,
   .i_sess_over_sel, .i_int_pin_en, .i_low_power, .i_scl, .i_sda, .o_sda_o, .o_sda_oe,
   .o_oe_int_n_o, .o_oe_int_oe, .o_int_pending
);

// ---- tb/oiu_host_model.sv ----
/* Host controller model: two-wire master with register write and read.
   Assumes the bench resolves SDA with a pull-up. */
`timescale 1ns/1ps
module oiu_host_model (
   input  wire logic i_core_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_oe
);
   // Idle bus: both lines released
   initial
   begin
      o_scl    = 1'b1;
      o_sda_oe = 1'b0;
   end
   // Eight cycles a phase covers the slave's 2-FF sync and answer delay
   task automatic ph();
      repeat (8) @(posedge i_core_clk);
   endtask
   // One bit slot; SDA only moves while SCL is low
   task automatic bit_io(input logic b, output logic r);
      o_sda_oe <= ~b;
      ph();
      o_scl <= 1'b1;
      ph();
      r = i_sda;
      o_scl <= 1'b0;
      ph();
   endtask
   // Start, also repeated start: SDA falls while SCL high
   task automatic start();
      o_sda_oe <= 1'b0;
      ph();
      o_scl <= 1'b1;
      ph();
      o_sda_oe <= 1'b1;
      ph();
      o_scl <= 1'b0;
      ph();
   endtask
   // Stop: SDA rises while SCL high
   task automatic stop();
      o_sda_oe <= 1'b1;
      ph();
      o_scl <= 1'b1;
      ph();
      o_sda_oe <= 1'b0;
      ph();
   endtask
   // Byte MSB first, then the acknowledge slot
   task automatic xbyte(input logic [7:0] d, input logic ai, output logic [7:0] q,
                        output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(ai, r);
      ack = ~r;
   endtask
   task automatic write(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                        output logic ok);
      logic [7:0] q;
      logic       k1, k2, k3;
      start();
      xbyte({dev, 1'b0}, 1'b1, q, k1);
      xbyte(a, 1'b1, q, k2);
      xbyte(d, 1'b1, q, k3);
      stop();
      ok = k1 & k2 & k3;
   endtask
   // Pointer write, repeated start, one byte read ended by a NACK
   task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic       k1, k2, k3, k4;
      start();
      xbyte({oiu_pkg::DEV_ADDR, 1'b0}, 1'b1, q, k1);
      xbyte(a, 1'b1, q, k2);
      start();
      xbyte({oiu_pkg::DEV_ADDR, 1'b1}, 1'b1, q, k3);
      xbyte(8'hFF, 1'b1, d, k4);
      stop();
      ok = k1 & k2 & k3;
   endtask
endmodule // oiu_host_model

// ---- tb/tb_oiu_irq_unit.sv ----
/* Self-checking bench for the interrupt unit: reset values, live status,
   set/clear registers, edge latch and shared pin.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
module tb_oiu_irq_unit;
   logic       i_core_clk = 1'b0;
   logic       i_rst_n    = 1'b0;
   logic [8:0] src        = 9'h000;
   logic       aa         = 1'b0;
   logic       so         = 1'b0;
   logic       pin_en     = 1'b0;
   logic       lp         = 1'b0;
   logic       scl, host_oe, sda_oe, sda_o, sda, oe_n, oe_en, pend, ok;
   int         failures   = 0;
   int         compares   = 0;

   // Open-drain SDA with pull-up
   assign sda = ~host_oe & (sda_oe ? sda_o : 1'b1);

   initial
   begin
      forever #5 i_core_clk = ~i_core_clk;
   end

   oiu_irq_unit oiu_irq_unit_inst (
      .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_vbus_valid(src[0]),
      .i_sess_valid(src[1]), .i_dplus_high_flag(src[2]), .i_ident_grounded_flag(src[3]),
      .i_dminus_high_flag(src[4]), .i_ident_floating_flag(src[5]),
      .i_dplus_pullup_connect(src[6]), .i_carkit_pulse_flag(src[7]), .i_sess_end(src[8]),
      .i_autoattach_en(aa), .i_sess_over_sel(so), .i_int_pin_en(pin_en), .i_low_power(lp),
      .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
      .o_oe_int_n_o(oe_n), .o_oe_int_oe(oe_en), .o_int_pending(pend)
   );
   oiu_host_model oiu_host_model_inst (
      .i_core_clk(i_core_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe)
   );

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      oiu_host_model_inst.write(oiu_pkg::DEV_ADDR, a, d, ok);
      chk({7'h00, ok}, 8'h01, "write ack");
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      oiu_host_model_inst.read(a, q, ok);
      chk({7'h00, ok}, 8'h01, "read ack");
      chk(q, exp, "read data");
   endtask
   // Source change held long enough to pass the synchroniser
   task automatic drv(input int b, input logic v);
      @(posedge i_core_clk);
      src[b] <= v;
      repeat (8) @(posedge i_core_clk);
   endtask

   task automatic t_reset();
      rd(8'h0A, 8'h00);
      rd(8'h0D, 8'h00);
      rd(8'h0F, 8'h00);
      chk({7'h00, pend}, 8'h00, "pending");
      oiu_host_model_inst.write(oiu_pkg::DEV_ADDR ^ 7'h01, 8'h0E, 8'hFF, ok);
      chk({7'h00, ok}, 8'h00, "foreign address acked");
      rd(8'h0E, 8'h00);
      rd(8'h30, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_live();
      aa <= 1'b1;
      for (int b = 0; b < 9; b++)
      begin
         drv(b, 1'b1);
         rd(8'h08, (b == 8) ? 8'h00 : 8'h01 << b);
         drv(b, 1'b0);
      end
      aa <= 1'b0;
      so <= 1'b1;
      drv(8, 1'b1);
      rd(8'h08, 8'h40);
      aa <= 1'b1;
      rd(8'h08, 8'h00);
      wr(8'h08, 8'hFF);
      rd(8'h08, 8'h00);
      so <= 1'b0;
      aa <= 1'b0;
      rd(8'h08, 8'h00);
      drv(8, 1'b0);
      rd(8'h0A, 8'h00);
      $display("test live done");
   endtask
   task automatic t_regs();
      wr(8'h0E, 8'hA5);
      rd(8'h0F, 8'hA5);
      wr(8'h0F, 8'h05);
      rd(8'h0E, 8'hA0);
      wr(8'h0F, 8'hA0);
      wr(8'h0C, 8'h3C);
      wr(8'h0D, 8'h0C);
      rd(8'h0C, 8'h30);
      wr(8'h0D, 8'h30);
      pin_en <= 1'b1;
      lp <= 1'b1;
      wr(8'h0A, 8'h81);
      rd(8'h0B, 8'h81);
      chk({6'h00, oe_en, oe_n}, 8'h02, "pin driven low");
      wr(8'h0B, 8'h80);
      rd(8'h0A, 8'h01);
      lp <= 1'b0;
      wr(8'h0B, 8'h01);
      chk({6'h00, oe_en, pend}, 8'h00, "pin released");
      $display("test registers done");
   endtask
   task automatic t_edges();
      logic [7:0] m;
      aa <= 1'b1;
      for (int b = 0; b < 8; b++)
      begin
         m = 8'h01 << b;
         wr(8'h0E, m);
         drv(b, 1'b1);
         rd(8'h0A, m);
         chk({7'h00, pend}, 8'h01, "pending");
         wr(8'h0B, m);
         wr(8'h0F, m);
         wr(8'h0C, m);
         drv(b, 1'b0);
         rd(8'h0B, m);
         wr(8'h0B, m);
         wr(8'h0D, m);
         drv(b, 1'b1);
         drv(b, 1'b0);
      end
      rd(8'h0A, 8'h00);
      $display("test edges done");
   endtask

   task automatic report_and_stop();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Main sequence after a 2-cycle reset
   initial
   begin
      repeat (2) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      t_reset();
      t_live();
      t_regs();
      t_edges();
      report_and_stop();
   end
   // Watchdog at about 95k cycles; the full run needs about 81k cycles
   initial
   begin
      #950000;
      failures++;
      $display("ERROR %0t watchdog expired", $time);
      report_and_stop();
   end
endmodule // tb_oiu_irq_unit
